// ---- inc/mtc_pkg.sv ----
// Constants and types shared by the MAC transmit control block
package mtc_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] TX_CTRL_OFS = 8'h70; // transmit_control
  localparam logic [7:0] TX_DATA_OFS = 8'h78; // frame byte push
  localparam logic [7:0] TX_STAT_OFS = 8'h7C; // engine status
  // Bit positions inside transmit_control
  localparam int CTL_ICMP_BIT = 8; // icmp_checksum_insert_en
  localparam int CTL_TCP_BIT = 6; // tcp_checksum_insert_en
  localparam int CTL_IP_BIT = 5; // ip_header_checksum_insert_en
  localparam int CTL_FLUSH_BIT = 4; // flush_transmit_queue
  localparam int CTL_FC_BIT = 3; // transmit_flow_control_en
  localparam int CTL_PAD_BIT = 2; // short_frame_padding_en
  localparam int CTL_FCS_BIT = 1; // append_fcs_en
  localparam int CTL_RUN_BIT = 0; // transmitter_run
  localparam logic [15:0] TX_CTRL_RESET = 16'h0000;
  localparam logic [15:0] TX_CTRL_RW_MASK = 16'h017F; // Bits 15-9, 7 read 0
  // Frame byte push word and status layout
  localparam int DATA_LAST_BIT = 8;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_LEVEL_LSB = 8;
  localparam int STAT_COUNT_LSB = 16;
  // Queue shape
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 9;
  // Frame lengths before the FCS is added
  localparam logic [10:0] MIN_LEN_FCS = 11'h03C; // 60 + 4 FCS = 64
  localparam logic [10:0] MIN_LEN_RAW = 11'h040; // 64 with no FCS
  // Ethernet CRC-32, reflected form
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  // Header byte positions and codes used for classification
  localparam logic [10:0] POS_TYPE_HI = 11'h00C;
  localparam logic [10:0] POS_TYPE_LO = 11'h00D;
  localparam logic [10:0] POS_FRAG_HI = 11'h014;
  localparam logic [10:0] POS_FRAG_LO = 11'h015;
  localparam logic [10:0] POS_PROTO = 11'h017;
  localparam logic [15:0] ETH_IPV4 = 16'h0800;
  localparam logic [7:0] FRAG_HI_MASK = 8'h3F; // More-fragments + offset
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_ICMP = 8'h01;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Engine states and register selects
  typedef enum logic [1:0] {MTC_IDLE, MTC_DATA, MTC_PAD, MTC_FCS} mtc_state_e;
  typedef enum logic [1:0] {
    MTC_SEL_NONE, MTC_SEL_CTRL, MTC_SEL_DATA, MTC_SEL_STAT
  } mtc_sel_e;
endpackage

// ---- inc/mtc_fifo_if.sv ----
// Carrier between the transmit control logic and its byte queue
`timescale 1ns/10ps
`default_nettype none
interface mtc_fifo_if #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
);
  logic wr_valid; // Push request
  logic wr_ready; // Room for a word
  logic [WIDTH-1:0] wr_data;
  logic rd_valid; // Word waiting
  logic rd_ready; // Pop request
  logic [WIDTH-1:0] rd_data;
  logic flush; // Clears all words
  logic [$clog2(DEPTH):0] level; // Words held
  modport ctrl (
    output wr_valid, wr_data, rd_ready, flush,
    input wr_ready, rd_valid, rd_data, level
  );
  modport fifo (
    input wr_valid, wr_data, rd_ready, flush,
    output wr_ready, rd_valid, rd_data, level
  );
endinterface
`default_nettype wire

// ---- design/mtc_fifo.sv ----
// Transmit byte queue with flush
`timescale 1ns/10ps
`default_nettype none
module mtc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  mtc_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  // Pointers wrap in power-of-two storage only
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("mtc_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // Word storage
  logic [AW:0] wptr; // Write pointer, extra wrap bit
  logic [AW:0] rptr; // Read pointer, extra wrap bit
  logic [AW:0] next_wptr;
  logic [AW:0] next_rptr;
  logic push;
  logic pop;

  // Full and empty both blocked during flush
  assign port.level = wptr - rptr;
  assign port.wr_ready = (port.level != FULL) && !port.flush;
  assign port.rd_valid = (port.level != '0) && !port.flush;
  assign port.rd_data = mem[rptr[AW-1:0]];
  assign push = port.wr_valid && port.wr_ready;
  assign pop = port.rd_valid && port.rd_ready;

  // Pointer next values; flush returns both to the start
  always_comb begin
    next_wptr = wptr + (AW + 1)'(push);
    next_rptr = rptr + (AW + 1)'(pop);
    if (port.flush) begin
      next_wptr = '0;
      next_rptr = '0;
    end
  end

  // Pointer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Storage needs no reset; pointers guard it
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= port.wr_data;
    end
  end
endmodule
`default_nettype wire

// ---- design/mtc_top.sv ----
// MAC transmit control: registers, frame engine and flow control
`timescale 1ns/10ps
`default_nettype none
module mtc_top #(
  parameter int FIFO_DEPTH = mtc_pkg::FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_ins_ip,
  output logic tx_ins_tcp,
  output logic tx_ins_icmp,
  input wire logic full_duplex,
  input wire logic rx_buf_high,
  output logic pause_req,
  output logic back_pressure
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // Level must fit its status field
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_bad_depth
    $error("mtc_top: FIFO_DEPTH must be 2 to 128");
  end

  // Register select from a byte address; word aligned
  function automatic mtc_pkg::mtc_sel_e reg_sel(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    if (w == mtc_pkg::TX_CTRL_OFS) begin
      return mtc_pkg::MTC_SEL_CTRL;
    end else if (w == mtc_pkg::TX_DATA_OFS) begin
      return mtc_pkg::MTC_SEL_DATA;
    end else if (w == mtc_pkg::TX_STAT_OFS) begin
      return mtc_pkg::MTC_SEL_STAT;
    end
    return mtc_pkg::MTC_SEL_NONE;
  endfunction

  // One CRC-32 step over a byte, low bit first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mtc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  mtc_fifo_if #(.WIDTH(mtc_pkg::FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) fq ();

  mtc_fifo #(.WIDTH(mtc_pkg::FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(fq.fifo)
  );

  // Bus side state
  logic [15:0] ctl; // transmit_control
  logic [15:0] next_ctl;
  logic aw_held; // Write address captured
  logic next_aw_held;
  logic [7:0] aw_addr_q;
  logic [7:0] next_aw_addr_q;
  logic w_held; // Write data captured
  logic next_w_held;
  logic [15:0] wdata_q; // Upper half never reaches a register
  logic [15:0] next_wdata_q;
  logic [1:0] wstrb_q;
  logic [1:0] next_wstrb_q;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  mtc_pkg::mtc_sel_e wsel; // Decoded write target
  logic wr_go; // Write completes this cycle
  logic flushing;

  // Engine state
  mtc_pkg::mtc_state_e state;
  mtc_pkg::mtc_state_e next_state;
  logic next_tx_valid;
  logic [7:0] next_tx_data;
  logic next_tx_last;
  logic [31:0] crc; // Running CRC over sent bytes
  logic [31:0] next_crc;
  logic [10:0] count; // Bytes sent in this frame
  logic [10:0] next_count;
  logic [1:0] fcs_idx; // FCS byte being sent
  logic [1:0] next_fcs_idx;
  logic [15:0] snap; // Control bits frozen per frame
  logic [15:0] next_snap;
  logic type_hi_ok;
  logic next_type_hi_ok;
  logic is_ip; // Ethertype is IPv4
  logic next_is_ip;
  logic frag; // Fragment bits seen
  logic next_frag;
  logic [7:0] proto; // IP protocol byte
  logic [7:0] next_proto;
  logic [2:0] ins; // Insert requests: icmp, tcp, ip
  logic [2:0] next_ins;
  logic [15:0] frames; // Frames completed
  logic [15:0] next_frames;
  logic load; // Output register may take a byte
  logic emit;
  logic finish;
  logic [7:0] byte_in;
  logic [10:0] pad_target;

  // Flow control state
  logic rx_high_q;
  logic next_pause_req;
  logic next_back_pressure;

  assign flushing = ctl[mtc_pkg::CTL_FLUSH_BIT];
  assign fq.flush = flushing;
  assign wsel = reg_sel(aw_addr_q);
  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;
  // Byte push; bit 8 of the word marks the last byte of a frame
  assign fq.wr_valid = aw_held && w_held && !bvalid && !flushing &&
                       wsel == mtc_pkg::MTC_SEL_DATA && wstrb_q[0];
  assign fq.wr_data = wdata_q[mtc_pkg::FIFO_WIDTH-1:0];
  // A push into a full queue holds the write response: back-pressure
  assign wr_go = aw_held && w_held && !bvalid &&
                 (fq.wr_ready || !fq.wr_valid);
  assign tx_ins_icmp = ins[2];
  assign tx_ins_tcp = ins[1];
  assign tx_ins_ip = ins[0];

  // Write channel: address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr_q = aw_addr_q;
    next_w_held = w_held;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ctl = ctl;
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_wdata_q = wdata[15:0];
      next_wstrb_q = wstrb[1:0];
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wsel == mtc_pkg::MTC_SEL_NONE) ?
                   mtc_pkg::RESP_SLVERR : mtc_pkg::RESP_OKAY;
      // Status is read only; a write there is accepted and dropped
      if (wsel == mtc_pkg::MTC_SEL_CTRL) begin
        for (int b = 0; b < 2; b++) begin
          if (wstrb_q[b]) begin
            next_ctl[8*b +: 8] = wdata_q[8*b +: 8] &
                                 mtc_pkg::TX_CTRL_RW_MASK[8*b +: 8];
          end
        end
      end
    end
  end

  // Write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
      bvalid <= 1'b0;
      bresp <= mtc_pkg::RESP_OKAY;
      ctl <= mtc_pkg::TX_CTRL_RESET;
    end else begin
      aw_held <= next_aw_held;
      aw_addr_q <= next_aw_addr_q;
      w_held <= next_w_held;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ctl <= next_ctl;
    end
  end

  // Read channel: one cycle from address to data
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = 32'h00000000;
      next_rresp = mtc_pkg::RESP_OKAY;
      case (reg_sel(araddr))
        mtc_pkg::MTC_SEL_CTRL: begin
          next_rdata[15:0] = ctl;
        end
        mtc_pkg::MTC_SEL_STAT: begin
          next_rdata[mtc_pkg::STAT_ACTIVE_BIT] =
            ctl[mtc_pkg::CTL_RUN_BIT] || state != mtc_pkg::MTC_IDLE;
          next_rdata[mtc_pkg::STAT_BUSY_BIT] = state != mtc_pkg::MTC_IDLE;
          next_rdata[mtc_pkg::STAT_LEVEL_LSB +: LW] = fq.level;
          next_rdata[mtc_pkg::STAT_COUNT_LSB +: 16] = frames;
        end
        mtc_pkg::MTC_SEL_DATA: begin
          next_rdata = 32'h00000000; // Push port reads zero
        end
        default: begin
          next_rresp = mtc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= mtc_pkg::RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Frame engine: queue bytes, then padding, then FCS
  always_comb begin
    next_state = state;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_tx_last = tx_last;
    next_crc = crc;
    next_count = count;
    next_fcs_idx = fcs_idx;
    next_snap = snap;
    next_type_hi_ok = type_hi_ok;
    next_is_ip = is_ip;
    next_frag = frag;
    next_proto = proto;
    next_ins = ins;
    next_frames = frames;
    fq.rd_ready = 1'b0;
    emit = 1'b0;
    finish = 1'b0;
    byte_in = 8'h00;
    load = !tx_valid || tx_ready;
    // Padding stops at 60 when the FCS brings it to 64
    pad_target = snap[mtc_pkg::CTL_FCS_BIT] ?
                 mtc_pkg::MIN_LEN_FCS : mtc_pkg::MIN_LEN_RAW;
    if (tx_valid && tx_ready) begin
      next_tx_valid = 1'b0;
    end
    case (state)
      mtc_pkg::MTC_IDLE: begin
        // New frames start only while running
        if (ctl[mtc_pkg::CTL_RUN_BIT] && fq.rd_valid) begin
          next_state = mtc_pkg::MTC_DATA;
          next_snap = ctl;
          next_crc = mtc_pkg::CRC_INIT;
          next_count = 11'h000;
          next_fcs_idx = 2'h0;
          next_type_hi_ok = 1'b0;
          next_is_ip = 1'b0;
          next_frag = 1'b0;
          next_proto = 8'h00;
        end
      end
      mtc_pkg::MTC_DATA: begin
        // Run bit is ignored here so a stop never cuts the frame short; only flush drops it
        if (load && fq.rd_valid) begin
          fq.rd_ready = 1'b1;
          emit = 1'b1;
          byte_in = fq.rd_data[7:0];
          if (fq.rd_data[mtc_pkg::DATA_LAST_BIT]) begin
            if (snap[mtc_pkg::CTL_PAD_BIT] &&
                count + 11'h001 < pad_target) begin
              next_state = mtc_pkg::MTC_PAD;
            end else if (snap[mtc_pkg::CTL_FCS_BIT]) begin
              next_state = mtc_pkg::MTC_FCS;
            end else begin
              finish = 1'b1;
            end
          end
        end
      end
      mtc_pkg::MTC_PAD: begin
        // Zero bytes, still folded into the CRC
        if (load) begin
          emit = 1'b1;
          if (count + 11'h001 >= pad_target) begin
            if (snap[mtc_pkg::CTL_FCS_BIT]) begin
              next_state = mtc_pkg::MTC_FCS;
            end else begin
              finish = 1'b1;
            end
          end
        end
      end
      mtc_pkg::MTC_FCS: begin
        // Inverted CRC, least significant byte first
        if (load) begin
          next_tx_valid = 1'b1;
          next_tx_data = ~crc[{fcs_idx, 3'h0} +: 8];
          next_tx_last = 1'b0;
          next_fcs_idx = fcs_idx + 2'h1;
          finish = fcs_idx == 2'h3;
        end
      end
      default: begin
        next_state = mtc_pkg::MTC_IDLE;
      end
    endcase
    if (emit) begin
      next_tx_valid = 1'b1;
      next_tx_data = byte_in;
      next_tx_last = 1'b0;
      next_crc = crc_byte(crc, byte_in);
      next_count = count + 11'h001;
      // Header classification for the checksum requests
      if (count == mtc_pkg::POS_TYPE_HI) begin
        next_type_hi_ok = byte_in == mtc_pkg::ETH_IPV4[15:8];
      end
      if (count == mtc_pkg::POS_TYPE_LO) begin
        next_is_ip = type_hi_ok && byte_in == mtc_pkg::ETH_IPV4[7:0];
      end
      if (count == mtc_pkg::POS_FRAG_HI) begin
        next_frag = (byte_in & mtc_pkg::FRAG_HI_MASK) != 8'h00;
      end
      if (count == mtc_pkg::POS_FRAG_LO) begin
        next_frag = frag || byte_in != 8'h00;
      end
      if (count == mtc_pkg::POS_PROTO) begin
        next_proto = byte_in;
      end
    end
    if (finish) begin
      next_state = mtc_pkg::MTC_IDLE;
      next_tx_last = 1'b1;
      next_frames = frames + 16'h0001;
      next_ins[0] = snap[mtc_pkg::CTL_IP_BIT] && next_is_ip;
      next_ins[1] = snap[mtc_pkg::CTL_TCP_BIT] && next_is_ip &&
                    next_proto == mtc_pkg::PROTO_TCP;
      next_ins[2] = snap[mtc_pkg::CTL_ICMP_BIT] && next_is_ip &&
                    next_proto == mtc_pkg::PROTO_ICMP && !next_frag;
    end
    // Flush drops the frame in progress and clears the completed-frame count
    if (flushing) begin
      next_state = mtc_pkg::MTC_IDLE;
      next_count = 11'h000;
      next_frames = 16'h0000;
    end
  end

  // Engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= mtc_pkg::MTC_IDLE;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      crc <= mtc_pkg::CRC_INIT;
      count <= 11'h000;
      fcs_idx <= 2'h0;
      snap <= mtc_pkg::TX_CTRL_RESET;
      type_hi_ok <= 1'b0;
      is_ip <= 1'b0;
      frag <= 1'b0;
      proto <= 8'h00;
      ins <= 3'h0;
      frames <= 16'h0000;
    end else begin
      state <= next_state;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      tx_last <= next_tx_last;
      crc <= next_crc;
      count <= next_count;
      fcs_idx <= next_fcs_idx;
      snap <= next_snap;
      type_hi_ok <= next_type_hi_ok;
      is_ip <= next_is_ip;
      frag <= next_frag;
      proto <= next_proto;
      ins <= next_ins;
      frames <= next_frames;
    end
  end

  // Flow control: PAUSE on full duplex, back-pressure on half
  always_comb begin
    next_pause_req = ctl[mtc_pkg::CTL_FC_BIT] && full_duplex &&
                     rx_buf_high && !rx_high_q;
    next_back_pressure = ctl[mtc_pkg::CTL_FC_BIT] && !full_duplex &&
                         rx_buf_high;
  end

  // Flow control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_high_q <= 1'b0;
      pause_req <= 1'b0;
      back_pressure <= 1'b0;
    end else begin
      rx_high_q <= rx_buf_high;
      pause_req <= next_pause_req;
      back_pressure <= next_back_pressure;
    end
  end
endmodule
`default_nettype wire

// ---- bench/mtc_phy_model.sv ----
// Far-side byte sink model that collects frames and can stall
`timescale 1ns/10ps
`default_nettype none
module mtc_phy_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow, // Stall one cycle in four
  input wire logic clr, // Forget the collected frame
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] rx [0:127]; // Collected bytes
  int cnt; // Bytes taken
  int nlast; // End markers seen
  int lpos; // Index of the last end marker
  logic [1:0] cyc; // Stall phase
  // Ready pattern; a real line may hold off at any cycle
  always_ff @(posedge aclk) begin
    cyc <= aresetn ? cyc + 2'h1 : 2'h0;
    tx_ready <= aresetn && (!slow || cyc != 2'h0);
  end
  // Byte capture, only on a real handshake
  always_ff @(posedge aclk) begin
    if (clr || !aresetn) begin
      cnt <= 0;
      nlast <= 0;
    end else if (tx_valid && tx_ready) begin
      rx[cnt] <= tx_data;
      cnt <= cnt + 1;
      if (tx_last) begin
        nlast <= nlast + 1;
        lpos <= cnt;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/mtc_top_props.sv ----
// Port checker for the MAC transmit control block
`timescale 1ns/10ps
`default_nettype none
module mtc_top_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ins_ip,
  input wire logic tx_ins_tcp,
  input wire logic tx_ins_icmp,
  input wire logic full_duplex,
  input wire logic rx_buf_high,
  input wire logic pause_req,
  input wire logic back_pressure
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid
    && $stable(rdata) && $stable(rresp)) else $error("read answer unstable");
  chk_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_r_close: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer not withdrawn");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid
    && $stable(tx_data) && $stable(tx_last)) else $error("byte not held");
  chk_tx_gap: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("no idle cycle after frame");
  chk_ins_at_last: assert property ($changed({tx_ins_ip,
    tx_ins_tcp, tx_ins_icmp}) |-> tx_valid && tx_last)
    else $error("insert flag moved");
  chk_pause_cause: assert property (pause_req |-> $past(rx_buf_high)
    && !$past(rx_buf_high, 2) && $past(full_duplex))
    else $error("pause without cause");
  chk_pause_pulse: assert property (pause_req |=> !pause_req)
    else $error("pause request too long");
  chk_bp_cause: assert property (back_pressure |-> $past(rx_buf_high)
    && !$past(full_duplex)) else $error("back pressure without cause");
endmodule
bind mtc_top mtc_top_props u_props (.aclk, .aresetn, .arvalid, .arready,
  .rvalid, .rready, .rdata, .rresp, .bvalid, .bready, .bresp, .tx_valid,
  .tx_ready, .tx_data, .tx_last, .tx_ins_ip, .tx_ins_tcp, .tx_ins_icmp,
  .full_duplex, .rx_buf_high, .pause_req, .back_pressure);
`default_nettype wire

// ---- bench/mtc_top_tb.sv ----
// Self-checking bench for the MAC transmit control block
`timescale 1ns/10ps
`default_nettype none
module mtc_top_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready;
  logic tx_last, tx_ins_ip, tx_ins_tcp, tx_ins_icmp, pause_req;
  logic full_duplex, rx_buf_high, slow, clr, back_pressure;
  logic [7:0] awaddr, araddr, tx_data;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  int error_cnt, check_count, npause, n;
  // Frame cases: control word, protocol, fragment byte, length, flags
  logic [15:0] t_ctl [4] = '{16'h0167, 16'h0167, 16'h0161, 16'h0003};
  logic [7:0] t_pro [4] = '{8'h06, 8'h01, 8'h01, 8'h06};
  logic [7:0] t_frg [4] = '{8'h00, 8'h00, 8'h20, 8'h00};
  int t_len [4] = '{64, 64, 24, 28};
  logic [2:0] t_ins [4] = '{3'h6, 3'h5, 3'h4, 3'h0};
  mtc_top #(.FIFO_DEPTH(32)) u_dut (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_ins_ip, .tx_ins_tcp,
    .tx_ins_icmp, .full_duplex, .rx_buf_high, .pause_req, .back_pressure);
  mtc_phy_model u_phy (.aclk, .aresetn, .slow, .clr, .tx_valid, .tx_data,
    .tx_last, .tx_ready);
  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Pause pulses counted here so none slips between checks
  always @(posedge aclk) if (pause_req === 1'b1) npause <= npause + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // Bus write; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Header byte i of case k
  function automatic logic [7:0] hdr(input int i, input int k);
    if (i == 12) return 8'h08;
    if (i == 13 || i == 21) return 8'h00;
    if (i == 20) return t_frg[k];
    return (i == 23) ? t_pro[k] : i[7:0];
  endfunction
  // Reference frame check sequence, reflected form
  function automatic logic [31:0] crc(input int n, input int k);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, (i < 24) ? hdr(i, k) : 8'h00};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ mtc_pkg::CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    final_report;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {full_duplex, rx_buf_high, slow, clr} = 4'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {error_cnt, check_count} = 64'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset value, writable mask, unmapped place
    rdr(mtc_pkg::TX_CTRL_OFS);
    chk(rd, 32'h0);
    wr(mtc_pkg::TX_CTRL_OFS, 32'hFFEF);
    rdr(mtc_pkg::TX_CTRL_OFS);
    chk(rd, 32'h016F);
    rdr(8'h40);
    chk({rd[29:0], resp}, 32'h2);
    wr(8'h40, 32'h1);
    chk(32'(resp), 32'h2);
    // Frames: held while stopped, finished after a mid-frame stop
    for (int k = 0; k < 4; k++) begin
      slow <= (k % 2 == 0);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      wr(mtc_pkg::TX_CTRL_OFS, {16'h0, t_ctl[k] & 16'hFFFE});
      for (int i = 0; i < 24; i++)
        wr(mtc_pkg::TX_DATA_OFS, {23'h0, 1'(i == 23), hdr(i, k)});
      repeat (10) @(posedge aclk);
      chk(u_phy.cnt, 0);
      wr(mtc_pkg::TX_CTRL_OFS, {16'h0, t_ctl[k]});
      wait (u_phy.cnt > 2);
      wr(mtc_pkg::TX_CTRL_OFS, {16'h0, t_ctl[k] & 16'hFFFE});
      wait (u_phy.nlast > 0);
      repeat (4) @(posedge aclk);
      chk(u_phy.cnt, t_len[k]);
      chk(u_phy.lpos, t_len[k] - 1);
      chk({tx_ins_ip, tx_ins_tcp, tx_ins_icmp}, t_ins[k]);
      n = t_ctl[k][1] ? t_len[k] - 4 : t_len[k];
      for (int i = 0; i < n; i++)
        chk(u_phy.rx[i], (i < 24) ? hdr(i, k) : 8'h00);
      if (t_ctl[k][1])
        chk({u_phy.rx[n+3], u_phy.rx[n+2], u_phy.rx[n+1], u_phy.rx[n]},
          crc(n, k));
    end
    // Fill the queue, flush with the transmitter stopped
    for (int i = 0; i < 32; i++) wr(mtc_pkg::TX_DATA_OFS, 32'(i));
    rdr(mtc_pkg::TX_STAT_OFS);
    chk(rd, 32'h00042000);
    wr(mtc_pkg::TX_CTRL_OFS, 32'h0010);
    rdr(mtc_pkg::TX_STAT_OFS);
    chk(rd, 32'h0);
    wr(mtc_pkg::TX_CTRL_OFS, 32'h0001);
    repeat (10) @(posedge aclk);
    chk(u_phy.cnt, 28);
    // Flow control: full duplex, half duplex, disabled
    for (int i = 0; i < 3; i++) begin
      wr(mtc_pkg::TX_CTRL_OFS, {28'h0, 1'(i < 2), 3'h1});
      n = npause;
      full_duplex <= (i != 1);
      @(posedge aclk);
      rx_buf_high <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(back_pressure, i == 1);
      rx_buf_high <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(npause - n, i == 0);
    end
    final_report;
  end
endmodule
`default_nettype wire
